// [inc/bmam_pkg.sv]
// constants for the banked memory address map
package bmam_pkg;
  localparam int PC_W = 13;
  localparam int PMEM_WORDS = 8192;
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] INTR_VEC = 13'h0004;
  localparam logic [12:0] PC_ONE = 13'h0001;
  localparam int LOC_W = 7;
  localparam int EA_W = 9;
  localparam int DATA_W = 8;
  localparam int BANK_LO_BIT = 5;
  localparam int BANK_HI_BIT = 6;
  localparam int PTR_BANK_BIT = 7;
  localparam int NUM_BANKS = 4;
  localparam int LATCH_W = 5;
  localparam logic [6:0] OFS_INDIRECT = 7'h00;
  localparam logic [6:0] OFS_PC_LOW = 7'h02;
  localparam logic [6:0] OFS_STATUS = 7'h03;
  localparam logic [6:0] OFS_FILE_PTR = 7'h04;
  localparam logic [6:0] OFS_PC_LATCH = 7'h0a;
  localparam logic [6:0] GPR_BASE = 7'h20;
  localparam int GPR_PER_BANK = 96;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] FILE_PTR_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [4:0] PC_LATCH_RST = 5'h00;
  typedef enum logic [3:0] {
    BMAM_Q1 = 4'h1,
    BMAM_Q2 = 4'h2,
    BMAM_Q3 = 4'h4,
    BMAM_Q4 = 4'h8
  } bmam_quarter_t;
endpackage : bmam_pkg

// [inc/bmam_pc_if.sv]
// link between the map top and its program counter unit
`timescale 1ns/1ps
interface bmam_pc_if;
  logic step;
  logic load;
  logic [12:0] load_addr;
  logic vector_take;
  logic [12:0] pc;
  modport top (output step, output load, output load_addr, output vector_take, input pc);
  modport unit (input step, input load, input load_addr, input vector_take, output pc);
endinterface : bmam_pc_if

// [logic/bmam_pc_unit.sv]
// program counter with wraparound and fixed vectors
`timescale 1ns/1ps
module bmam_pc_unit #(
  parameter int PMEM_WORDS = bmam_pkg::PMEM_WORDS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control and counter value
  bmam_pc_if.unit program_counter_low
);
  // power of two sizes only: the wrap is a mask on the upper bits
  localparam logic [12:0] WRAP_MASK = 13'(PMEM_WORDS - 1);

  logic [12:0] pc_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_q <= bmam_pkg::RESET_VEC; // RQ3
    end else if (program_counter_low.vector_take) begin
      pc_q <= bmam_pkg::INTR_VEC; // RQ4
    end else if (program_counter_low.load) begin
      pc_q <= program_counter_low.load_addr & WRAP_MASK; // RQ2
    end else if (program_counter_low.step) begin
      pc_q <= (pc_q + bmam_pkg::PC_ONE) & WRAP_MASK; // RQ1 RQ2
    end
  end

  assign program_counter_low.pc = pc_q;
endmodule : bmam_pc_unit

// [logic/bmam_addr_map.sv]
// banked data memory decode, core registers and program fetch address
// What this block does
// RQ1 - thirteen bit program counter addresses up to 8K program words.
// RQ2 - fetch addresses above the implemented program memory wrap back into it.
// RQ3 - after reset the first instruction is fetched from address zero.
// RQ4 - a taken interrupt redirects fetch to program address four.
// RQ5 - status bits 6:5 select one of four data banks.
// RQ6 - each bank holds local addresses 00h to 7Fh, 128 bytes.
// RQ7 - low addresses hold special registers, 20h upward general purpose RAM.
// RQ8 - frequently used special registers appear at the same offset in every bank.
// RQ9 - data is reached directly or indirectly through the file pointer at 04h.
// RQ10 - reads of unimplemented locations return zero.
// RQ11 - offsets 00h and 80h have no storage, they access through the pointer.
// RQ12 - operand read happens in quarter two, destination write in quarter four.
// RQ13 - direct address is the bank select bits above the seven-bit address.
`timescale 1ns/1ps
module bmam_addr_map #(
  parameter int PMEM_WORDS = bmam_pkg::PMEM_WORDS,
  parameter int NUM_BANKS = bmam_pkg::NUM_BANKS,
  parameter int GPR_PER_BANK = bmam_pkg::GPR_PER_BANK
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // program flow from the core, sampled in quarter one
  input wire logic branch_valid,
  input wire logic [12:0] branch_target,
  input wire logic intr_take,
  // operand access from the core
  input wire logic [6:0] op_addr,
  input wire logic op_rd,
  input wire logic op_wr,
  input wire logic [7:0] op_wdata,
  // results
  output logic [12:0] fetch_addr,
  output logic [3:0] quarter_q,
  output logic [7:0] op_rdata_q,
  output logic [7:0] core_status_q,
  output logic [7:0] file_pointer_q
);
  localparam int GPR_WORDS = NUM_BANKS * GPR_PER_BANK;
  localparam int IDX_W = $clog2(GPR_WORDS);

  // phase, address and strobe signals
  bmam_pc_if program_counter_low ();
  bmam_pkg::bmam_quarter_t quarter_d;
  bmam_pkg::bmam_quarter_t quarter_cur;
  logic [4:0] program_counter_high_latch_q;
  logic [8:0] eff_addr;
  logic [8:0] wr_addr_q;
  logic [7:0] gpr_mem [GPR_WORDS];
  logic [7:0] rd_value;
  logic in_q1;
  logic in_q2;
  logic in_q4;
  logic wr_fire;
  logic rd_fire;
  logic wr_status;
  logic wr_file_ptr;
  logic wr_pc_latch;
  logic wr_pc_low;

  // bank number of a full address
  function automatic int bank_of(input logic [8:0] ea);
    bank_of = int'(ea[bmam_pkg::EA_W-1:bmam_pkg::LOC_W]);
  endfunction : bank_of

  // local offset inside a bank
  function automatic logic [6:0] local_ofs(input logic [8:0] ea);
    local_ofs = ea[bmam_pkg::LOC_W-1:0];
  endfunction : local_ofs

  // true when a full address lands in implemented general purpose RAM
  function automatic logic is_gpr(input logic [8:0] ea);
    is_gpr = (local_ofs(ea) >= bmam_pkg::GPR_BASE) && (bank_of(ea) < NUM_BANKS); // RQ7 RQ10
  endfunction : is_gpr

  // flat ram index for a bank and local offset
  function automatic logic [IDX_W-1:0] gpr_index(input logic [8:0] ea);
    logic [6:0] loc;
    loc = local_ofs(ea) - bmam_pkg::GPR_BASE;
    gpr_index = IDX_W'(bank_of(ea) * GPR_PER_BANK + int'(loc)); // RQ6
  endfunction : gpr_index

  // special register hit: outside ram, matching local offset, in any bank
  function automatic logic sfr_hit(input logic [8:0] ea, input logic [6:0] ofs);
    sfr_hit = !is_gpr(ea) && (local_ofs(ea) == ofs); // RQ8
  endfunction : sfr_hit

  // effective address: direct or through the pointer
  function automatic logic [8:0] resolve(input logic [6:0] a, input logic [7:0] st,
                                         input logic [7:0] fp);
    if (a == bmam_pkg::OFS_INDIRECT) begin
      resolve = {st[bmam_pkg::PTR_BANK_BIT], fp}; // RQ9 RQ11
    end else begin
      resolve = {st[bmam_pkg::BANK_HI_BIT], st[bmam_pkg::BANK_LO_BIT], a}; // RQ5 RQ13
    end
  endfunction : resolve

  // quarter phase divider; each phase is one clk
  always_comb begin
    quarter_cur = bmam_pkg::bmam_quarter_t'(quarter_q);
    case (quarter_cur)
      bmam_pkg::BMAM_Q1: quarter_d = bmam_pkg::BMAM_Q2;
      bmam_pkg::BMAM_Q2: quarter_d = bmam_pkg::BMAM_Q3;
      bmam_pkg::BMAM_Q3: quarter_d = bmam_pkg::BMAM_Q4;
      bmam_pkg::BMAM_Q4: quarter_d = bmam_pkg::BMAM_Q1;
      default: quarter_d = bmam_pkg::BMAM_Q1;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quarter_q <= bmam_pkg::BMAM_Q1;
    end else begin
      quarter_q <= quarter_d;
    end
  end

  // phase strobes from the one-hot quarter register
  assign in_q1 = (quarter_q == bmam_pkg::BMAM_Q1);
  assign in_q2 = (quarter_q == bmam_pkg::BMAM_Q2);
  assign in_q4 = (quarter_q == bmam_pkg::BMAM_Q4);
  assign rd_fire = op_rd && in_q2; // RQ12
  assign wr_fire = op_wr && in_q4; // RQ12
  assign eff_addr = resolve(op_addr, core_status_q, file_pointer_q);

  // address latched at the read so a write in the same cycle sees the old pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_addr_q <= '0;
    end else if (in_q2) begin
      wr_addr_q <= eff_addr;
    end
  end

  // read value; special registers decode on the local offset in any bank
  always_comb begin
    rd_value = bmam_pkg::BYTE_ZERO;
    if (is_gpr(eff_addr)) begin
      rd_value = gpr_mem[gpr_index(eff_addr)];
    end else begin
      case (local_ofs(eff_addr)) // RQ8
        bmam_pkg::OFS_PC_LOW: rd_value = program_counter_low.pc[7:0];
        bmam_pkg::OFS_STATUS: rd_value = core_status_q;
        bmam_pkg::OFS_FILE_PTR: rd_value = file_pointer_q;
        bmam_pkg::OFS_PC_LATCH: rd_value = {3'h0, program_counter_high_latch_q};
        // pointer to itself and peripheral slots read back zero
        default: rd_value = bmam_pkg::BYTE_ZERO; // RQ10 RQ11
      endcase
    end
  end

  // operand read taken at the end of quarter two, held until the next read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_rdata_q <= bmam_pkg::BYTE_ZERO;
    end else if (rd_fire) begin
      op_rdata_q <= rd_value; // RQ12
    end
  end

  // general purpose ram: no reset, contents undefined at power up
  always_ff @(posedge clk) begin
    if (wr_fire && is_gpr(wr_addr_q)) begin
      gpr_mem[gpr_index(wr_addr_q)] <= op_wdata; // RQ7
    end
  end

  // write strobes decoded on the address latched at quarter two
  always_comb begin
    wr_status = wr_fire && sfr_hit(wr_addr_q, bmam_pkg::OFS_STATUS);
    wr_file_ptr = wr_fire && sfr_hit(wr_addr_q, bmam_pkg::OFS_FILE_PTR);
    wr_pc_latch = wr_fire && sfr_hit(wr_addr_q, bmam_pkg::OFS_PC_LATCH);
    wr_pc_low = wr_fire && sfr_hit(wr_addr_q, bmam_pkg::OFS_PC_LOW);
  end

  // status kept as a whole byte: bank field and indirect bank bit both live in it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_status_q <= bmam_pkg::STATUS_RST;
    end else if (wr_status) begin
      core_status_q <= op_wdata; // RQ5 RQ8
    end
  end

  // the pointer is a plain byte; status bit 7 picks which half of the map it reaches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      file_pointer_q <= bmam_pkg::FILE_PTR_RST;
    end else if (wr_file_ptr) begin
      file_pointer_q <= op_wdata; // RQ9 RQ8
    end
  end

  // only the bits that reach the counter are stored, the rest read back zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      program_counter_high_latch_q <= bmam_pkg::PC_LATCH_RST;
    end else if (wr_pc_latch) begin
      program_counter_high_latch_q <= op_wdata[4:0]; // RQ8
    end
  end

  // program counter control: interrupt beats branch beats step, all in quarter one;
  // a low byte write reloads the whole counter from the latch at quarter four
  assign program_counter_low.step = in_q1; // RQ1
  assign program_counter_low.vector_take = intr_take && in_q1; // RQ4
  assign program_counter_low.load = wr_pc_low || (branch_valid && in_q1);
  assign program_counter_low.load_addr = wr_pc_low ? {program_counter_high_latch_q, op_wdata} : branch_target;

  bmam_pc_unit #(
    .PMEM_WORDS(PMEM_WORDS)
  ) u_pc (
    .clk(clk),
    .rst(rst),
    .program_counter_low(program_counter_low.unit)
  );

  // fetch address is the counter flop itself, with no logic after it
  assign fetch_addr = program_counter_low.pc; // RQ3
endmodule : bmam_addr_map

// [test/bmam_addr_map_sva.sv]
// assertions on the address map top ports
`timescale 1ns/1ps
module bmam_addr_map_sva #(parameter int PMEM_WORDS = 8192) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // core requests
  input wire logic branch_valid,
  input wire logic [12:0] branch_target,
  input wire logic intr_take,
  input wire logic [6:0] op_addr,
  input wire logic op_rd,
  input wire logic op_wr,
  input wire logic [7:0] op_wdata,
  // results
  input wire logic [12:0] fetch_addr,
  input wire logic [3:0] quarter_q,
  input wire logic [7:0] op_rdata_q,
  input wire logic [7:0] core_status_q,
  input wire logic [7:0] file_pointer_q
);
  localparam logic [12:0] MASK = 13'(PMEM_WORDS - 1);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_QWRAP: assert property (quarter_q == 4'h8 |=> quarter_q == 4'h1)
    else $error("quarter wrap");
  AST_INTR: assert property (quarter_q == 4'h1 && intr_take |=> fetch_addr == 13'h0004)
    else $error("intr vector");
  AST_BR: assert property (quarter_q == 4'h1 && branch_valid && !intr_take
    |=> fetch_addr == ($past(branch_target) & MASK)) else $error("branch wrap");
  AST_STEP: assert property (quarter_q == 4'h1 && !branch_valid && !intr_take
    |=> fetch_addr == (($past(fetch_addr) + 13'h0001) & MASK)) else $error("pc step");
  AST_RDQ2: assert property (quarter_q != 4'h2 |=> $stable(op_rdata_q))
    else $error("read outside q2");
  AST_FP: assert property (quarter_q == 4'h8 && op_wr && $past(op_addr, 2) == 7'h04
    |=> file_pointer_q == $past(op_wdata)) else $error("pointer write");
  AST_ST: assert property (quarter_q == 4'h8 && op_wr && $past(op_addr, 2) == 7'h03
    |=> core_status_q == $past(op_wdata)) else $error("status write");
  AST_UNIMP: assert property (quarter_q == 4'h2 && op_rd && op_addr == 7'h01
    |=> op_rdata_q == 8'h00) else $error("unimplemented read");
endmodule : bmam_addr_map_sva

// [test/bmam_core_model.sv]
// core model issuing one instruction cycle at a time
`timescale 1ns/1ps
module bmam_core_model (
  // timing from the map
  input wire logic clk,
  input wire logic [3:0] quarter_q,
  input wire logic [7:0] op_rdata_q,
  // requests to the map
  output logic branch_valid,
  output logic [12:0] branch_target,
  output logic intr_take,
  output logic [6:0] op_addr,
  output logic op_rd,
  output logic op_wr,
  output logic [7:0] op_wdata
);
  initial begin
    {branch_valid, branch_target, intr_take, op_addr, op_rd, op_wr, op_wdata} = '0;
  end
  // address held all cycle since the write target resolves in q2; released address, data and target lines invert, strobes drop
  task automatic cycle(input logic [6:0] a, input logic rd, input logic wr, input logic [7:0] wd,
      input logic bv, input logic it, input logic [12:0] bt, output logic [7:0] r);
    // let a clock pass after the previous release before raising the next request
    @(negedge clk);
    while (quarter_q !== 4'h1) @(negedge clk);
    {op_addr, op_rd, op_wr, op_wdata, branch_valid, intr_take, branch_target} = {a, rd, wr, wd, bv, it, bt};
    @(negedge clk);
    {branch_valid, intr_take, branch_target} = {2'b00, ~bt};
    @(negedge clk);
    r = op_rdata_q;
    op_rd = 1'b0;
    repeat (2) @(negedge clk);
    {op_wr, op_addr, op_wdata} = {1'b0, ~a, ~wd};
  endtask : cycle
endmodule : bmam_core_model

// [test/banked_memory_address_map_bench.sv]
// bench for the banked memory address map
`timescale 1ns/1ps
module banked_memory_address_map_bench;
  localparam int PW = 2048;
  logic clk = 1'b0, rst = 1'b1, branch_valid, intr_take, op_rd, op_wr;
  logic [12:0] branch_target, fetch_addr;
  logic [6:0] op_addr;
  logic [7:0] op_wdata, op_rdata_q, core_status_q, file_pointer_q, r;
  logic [3:0] quarter_q;
  int n_errors = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  bmam_addr_map #(.PMEM_WORDS(PW)) uut (.clk, .rst, .branch_valid, .branch_target, .intr_take,
    .op_addr, .op_rd, .op_wr, .op_wdata, .fetch_addr, .quarter_q, .op_rdata_q, .core_status_q,
    .file_pointer_q);
  bmam_core_model core (.clk, .quarter_q, .op_rdata_q, .branch_valid, .branch_target,
    .intr_take, .op_addr, .op_rd, .op_wr, .op_wdata);
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(input logic [6:0] a, input logic w, input logic [7:0] d);
    core.cycle(a, !w, w, d, 1'b0, 1'b0, 13'h0000, r);
  endtask : acc
  task automatic t_reset();
    chk("fetch", 13'h0000, fetch_addr);
    chk("quarter", 13'h0001, quarter_q);
    acc(7'h01, 1'b0, 8'h00);
    chk("unimpl", 13'h0000, r);
    // one idle instruction cycle plus the read: two steps since reset
    chk("fetch", 13'h0002, fetch_addr);
  endtask : t_reset
  task automatic t_data();
    acc(7'h04, 1'b1, 8'h25);
    chk("pointer reg", 13'h0025, file_pointer_q);
    acc(7'h04, 1'b0, 8'h00);
    chk("pointer", 13'h0025, r);
    acc(7'h20, 1'b1, 8'ha5);
    acc(7'h03, 1'b1, 8'h20);
    chk("status", 13'h0020, core_status_q);
    acc(7'h20, 1'b1, 8'h3c);
    acc(7'h7f, 1'b1, 8'h5a);
    acc(7'h7f, 1'b0, 8'h00);
    chk("ram top", 13'h005a, r);
    acc(7'h0a, 1'b1, 8'hff);
    acc(7'h03, 1'b1, 8'h00);
    acc(7'h0a, 1'b0, 8'h00);
    chk("latch mirror", 13'h001f, r);
    acc(7'h20, 1'b0, 8'h00);
    chk("bank0 ram", 13'h00a5, r);
    acc(7'h04, 1'b1, 8'hff);
    acc(7'h00, 1'b0, 8'h00);
    chk("indirect", 13'h005a, r);
    acc(7'h04, 1'b1, 8'h00);
    acc(7'h00, 1'b0, 8'h00);
    chk("self indirect", 13'h0000, r);
  endtask : t_data
  task automatic t_pc();
    core.cycle(7'h01, 1'b1, 1'b0, 8'h00, 1'b1, 1'b0, 13'h1805, r);
    chk("branch wrap", 13'h0005, fetch_addr);
    core.cycle(7'h01, 1'b1, 1'b0, 8'h00, 1'b1, 1'b1, 13'h1805, r);
    chk("intr vector", 13'h0004, fetch_addr);
    acc(7'h02, 1'b1, 8'h10);
    chk("pc load", 13'h0710, fetch_addr);
  endtask : t_pc
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    close_out();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_data();
    t_pc();
    close_out();
  end
endmodule : banked_memory_address_map_bench
bind bmam_addr_map bmam_addr_map_sva #(.PMEM_WORDS(PMEM_WORDS)) chk_i (.clk, .rst, .branch_valid,
  .branch_target, .intr_take, .op_addr, .op_rd, .op_wr, .op_wdata, .fetch_addr, .quarter_q,
  .op_rdata_q, .core_status_q, .file_pointer_q);
